// ### core/dec_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef DEC_REGS_SVH
`define DEC_REGS_SVH

`define DEC_OFS_ECC_CONTROL 8'h71
`define DEC_OFS_ECC_SHIFT_COUNTER 8'h72
`define DEC_OFS_ECC_STATUS0 8'h73
`define DEC_OFS_ECC_STATUS1 8'h74
`define DEC_OFS_ECC_STATUS2 8'h75
`define DEC_OFS_ECC_STATUS3 8'h76
`define DEC_OFS_FMT_MODE 8'h77

`define DEC_CTL_CORRECT 0
`define DEC_CTL_SHIFT 1
`define DEC_CTL_NOFB 2
`define DEC_CTL_CLEAR 3
`define DEC_CTL_SECT_BR 4
`define DEC_CTL_FMT_RST 5
`define DEC_CTL_REVERSE 7

`define DEC_MODE_FILT_OFF 0
`define DEC_MODE_INT_ACC 1
`define DEC_MODE_INT_LOW 2
`define DEC_MODE_INT_EN 3
`define DEC_MODE_PU_OFF 4
`define DEC_MODE_FIRE 5
`define DEC_MODE_ALT_BR 6

`define DEC_CTL_RESET 8'h20
`define DEC_CTL_KEEP_MASK 8'h20
`define DEC_MODE_RESET 8'h00
`define DEC_CNT_RESET 8'h00

`define DEC_INT_LOW_BASE 8'h40
`define DEC_INT_LOW_LAST 8'h47
`define DEC_INT_HIGH_BASE 8'h60
`define DEC_INT_HIGH_LAST 8'h6F

`define DEC_CORR_MAX_BYTES 9'd256
`define DEC_FILT_CYCLES 2'd2

`endif

// ### core/dec_pkg.sv
// types shared by the disk ecc control block
package dec_pkg;

    typedef struct packed {
        logic ale;
        logic rd_n;
        logic wr_n;
        logic index_pin;
        logic sector_pin;
        logic ref_clk;
        logic [7:0] ad;
    } dec_pins_t;

    typedef enum logic [1:0] {
        DEC_IDLE,
        DEC_REVERSE,
        DEC_CORRECT
    } dec_eng_t;

endpackage : dec_pkg

// ### core/dec_ctrl.sv
// ecc control, syndrome status and formatter mode logic behind the muxed bus
`timescale 1ns/1ps
`include "dec_regs.svh"
`default_nettype none

module dec_ctrl #(
    parameter logic [55:0] POLY56_FWD = 56'h00_0000_0000_0001,
    parameter logic [55:0] POLY56_REV = 56'h80_0000_0000_0000,
    parameter logic [55:0] POLY32_FWD = 56'h00_0000_0000_0001,
    parameter logic [55:0] POLY32_REV = 56'h00_0000_8000_0000
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire dec_pkg::dec_pins_t pins,
    input wire logic disk_op_active,
    input wire logic data_bit,
    input wire logic data_bit_valid,
    input wire logic cw_ctl_bit3,
    input wire logic int_request,
    output logic [7:0] ad_out,
    output logic ad_oe,
    output logic int_n_out,
    output logic int_n_oe,
    output logic int_pullup_en,
    output logic int_reg_sel,
    output logic fmt_reset,
    output logic nrz_hiz,
    output logic mark_or_sector_pin_hiz,
    output logic branch_start,
    output logic ref_clk_clean,
    output logic invalid_nrz,
    output logic alt_branch_en,
    output logic correctable_found,
    output logic ecc_busy
);

    // ======================================================
    // pin synchronisers
    dec_pkg::dec_pins_t s1_ff, s2_ff, s3_ff, pin_ff, pin_prev_ff;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_ff <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            s2_ff <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            s3_ff <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            pin_ff <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            pin_prev_ff <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, default: '0};
        end else begin
            s1_ff <= pins;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // a bit moves only once stages two and three agree
            pin_ff <= (s2_ff & s3_ff) | (pin_ff & (s2_ff ^ s3_ff));
            pin_prev_ff <= pin_ff;
        end
    end

    // ======================================================
    // functions
    function automatic logic [55:0] ecc_step(input logic [55:0] s, input logic din,
                                             input logic [55:0] poly, input logic fire,
                                             input logic nofb);
        logic fb;
        logic [55:0] sh;
        fb = (fire ? s[31] : s[55]) ^ din;
        sh = {s[54:0], nofb & din};
        if (!nofb && fb) begin
            sh = sh ^ poly;
        end
        if (fire) begin
            sh[55:32] = '0;
        end
        return sh;
    endfunction : ecc_step

    function automatic logic [7:0] stat_byte(input logic [55:0] s, input logic fire, input logic [1:0] k);
        logic [5:0] lo;
        lo = fire ? {1'b0, k, 3'b000} : 6'(6'd24 + {1'b0, k, 3'b000});
        return s[lo +: 8];
    endfunction : stat_byte

    // ======================================================
    // bus cycle decode
    logic [7:0] addr_ff, wdata_ff, ctl_ff, cnt_ff, mode_ff;
    logic wr_stb_ff;
    logic [55:0] syn_ff;
    dec_pkg::dec_eng_t eng_ff;
    logic soft_rst;

    assign soft_rst = ctl_ff[`DEC_CTL_FMT_RST];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            wr_stb_ff <= 1'b0;
        end else begin
            if (pin_prev_ff.ale && !pin_ff.ale) begin
                addr_ff <= pin_ff.ad;
            end
            if (!pin_ff.wr_n) begin
                wdata_ff <= pin_ff.ad;
            end
            wr_stb_ff <= !pin_prev_ff.wr_n && pin_ff.wr_n;
        end
    end

    logic wr_ctl, wr_cnt, wr_mode;
    assign wr_ctl = wr_stb_ff && addr_ff == `DEC_OFS_ECC_CONTROL;
    assign wr_cnt = wr_stb_ff && addr_ff == `DEC_OFS_ECC_SHIFT_COUNTER && !soft_rst;
    assign wr_mode = wr_stb_ff && addr_ff == `DEC_OFS_FMT_MODE && !soft_rst;

    // ======================================================
    // ecc control register
    logic eng_done, clr_now;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctl_ff <= `DEC_CTL_RESET;
        end else if (wr_ctl) begin
            ctl_ff <= wdata_ff;
        end else if (soft_rst) begin
            ctl_ff <= ctl_ff & `DEC_CTL_KEEP_MASK;
        end else begin
            if (eng_done) begin
                ctl_ff[`DEC_CTL_SHIFT] <= 1'b0;
            end
            if (clr_now) begin
                ctl_ff[`DEC_CTL_CLEAR] <= 1'b0;
            end
        end
    end

    assign clr_now = ctl_ff[`DEC_CTL_CLEAR] && !disk_op_active && !soft_rst;

    // ======================================================
    // mode register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_ff <= `DEC_MODE_RESET;
        end else if (soft_rst) begin
            mode_ff <= `DEC_MODE_RESET;
        end else if (wr_mode) begin
            mode_ff <= wdata_ff;
        end
    end

    // ======================================================
    // ecc engine
    logic fire;
    logic [2:0] bit_cnt_ff;
    logic [8:0] bytes_ff;
    logic [55:0] fwd_poly, rev_poly, syn_next;
    logic byte_end, hit;

    assign fire = mode_ff[`DEC_MODE_FIRE];
    assign fwd_poly = fire ? POLY32_FWD : POLY56_FWD;
    assign rev_poly = fire ? POLY32_REV : POLY56_REV;
    assign byte_end = bit_cnt_ff == 3'd7;
    assign syn_next = ecc_step(syn_ff, 1'b0, ctl_ff[`DEC_CTL_REVERSE] ? rev_poly : fwd_poly, fire,
                               ctl_ff[`DEC_CTL_NOFB]);
    // error confined to the low byte once shifted to a byte boundary
    assign hit = (fire ? syn_next[31:8] == 24'h0 : syn_next[55:8] == 48'h0) && syn_next[7:0] != 8'h00;
    assign eng_done = (eng_ff == dec_pkg::DEC_REVERSE && byte_end)
                   || (eng_ff == dec_pkg::DEC_CORRECT && byte_end
                       && (hit || bytes_ff == `DEC_CORR_MAX_BYTES - 9'd1));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            eng_ff <= dec_pkg::DEC_IDLE;
            bit_cnt_ff <= 3'd0;
            bytes_ff <= 9'd0;
        end else if (soft_rst) begin
            eng_ff <= dec_pkg::DEC_IDLE;
            bit_cnt_ff <= 3'd0;
            bytes_ff <= 9'd0;
        end else begin
            case (eng_ff)
                dec_pkg::DEC_IDLE: begin
                    bit_cnt_ff <= 3'd0;
                    bytes_ff <= 9'd0;
                    if (ctl_ff[`DEC_CTL_SHIFT]) begin
                        eng_ff <= ctl_ff[`DEC_CTL_CORRECT] ? dec_pkg::DEC_CORRECT : dec_pkg::DEC_REVERSE;
                    end
                end
                dec_pkg::DEC_REVERSE, dec_pkg::DEC_CORRECT: begin
                    bit_cnt_ff <= 3'(bit_cnt_ff + 3'd1);
                    if (byte_end) begin
                        bytes_ff <= 9'(bytes_ff + 9'd1);
                    end
                    if (eng_done) begin
                        eng_ff <= dec_pkg::DEC_IDLE;
                    end
                end
                default: eng_ff <= dec_pkg::DEC_IDLE;
            endcase
        end
    end

    // syndrome register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            syn_ff <= '1;
        end else if (soft_rst) begin
            syn_ff <= '1;
        end else if (clr_now) begin
            syn_ff <= fire ? 56'h0 : '1;
        end else if (eng_ff == dec_pkg::DEC_REVERSE) begin
            syn_ff <= ecc_step(syn_ff, cnt_ff[7], fwd_poly, fire, ctl_ff[`DEC_CTL_NOFB]);
        end else if (eng_ff == dec_pkg::DEC_CORRECT) begin
            syn_ff <= syn_next;
        end else if (data_bit_valid) begin
            syn_ff <= ecc_step(syn_ff, data_bit, fwd_poly, fire, ctl_ff[`DEC_CTL_NOFB]);
        end
    end

    // correction shift register / counter
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= `DEC_CNT_RESET;
        end else if (soft_rst) begin
            cnt_ff <= `DEC_CNT_RESET;
        end else if (eng_ff == dec_pkg::DEC_REVERSE) begin
            cnt_ff <= {cnt_ff[6:0], 1'b0};
        end else if (eng_ff == dec_pkg::DEC_CORRECT) begin
            if (byte_end && !hit) begin
                cnt_ff <= 8'(cnt_ff + 8'd1);
            end
        end else if (wr_cnt) begin
            cnt_ff <= wdata_ff;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            correctable_found <= 1'b0;
            ecc_busy <= 1'b0;
        end else begin
            if (soft_rst || (eng_ff == dec_pkg::DEC_IDLE && ctl_ff[`DEC_CTL_SHIFT])) begin
                correctable_found <= 1'b0;
            end else if (eng_ff == dec_pkg::DEC_CORRECT && byte_end && hit) begin
                correctable_found <= 1'b1;
            end
            // busy from the start cycle so all eight shifts are covered
            ecc_busy <= (eng_ff != dec_pkg::DEC_IDLE && !eng_done)
                        || (eng_ff == dec_pkg::DEC_IDLE && ctl_ff[`DEC_CTL_SHIFT] && !soft_rst);
        end
    end

    // ======================================================
    // read path
    logic [7:0] rdata;
    logic int_hit;

    always_comb begin
        case (addr_ff)
            `DEC_OFS_ECC_CONTROL: rdata = ctl_ff;
            `DEC_OFS_ECC_SHIFT_COUNTER: rdata = cnt_ff;
            `DEC_OFS_ECC_STATUS0: rdata = stat_byte(syn_ff, fire, 2'd0);
            `DEC_OFS_ECC_STATUS1: rdata = stat_byte(syn_ff, fire, 2'd1);
            `DEC_OFS_ECC_STATUS2: rdata = stat_byte(syn_ff, fire, 2'd2);
            `DEC_OFS_ECC_STATUS3: rdata = stat_byte(syn_ff, fire, 2'd3);
            `DEC_OFS_FMT_MODE: rdata = mode_ff;
            default: rdata = 8'h00;
        endcase
    end

    assign int_hit = mode_ff[`DEC_MODE_INT_ACC] && (mode_ff[`DEC_MODE_INT_LOW]
        ? (addr_ff >= `DEC_INT_LOW_BASE && addr_ff <= `DEC_INT_LOW_LAST)
        : (addr_ff >= `DEC_INT_HIGH_BASE && addr_ff <= `DEC_INT_HIGH_LAST));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ad_out <= 8'h00;
            ad_oe <= 1'b0;
            int_reg_sel <= 1'b0;
        end else begin
            ad_out <= rdata;
            // own registers only; the interrupt block drives its own reads
            ad_oe <= !pin_ff.rd_n && !soft_rst && addr_ff >= `DEC_OFS_ECC_CONTROL
                     && addr_ff <= `DEC_OFS_FMT_MODE;
            int_reg_sel <= int_hit && !soft_rst;
        end
    end

    // ======================================================
    // interrupt pin, reset outputs, branch and filter
    logic [1:0] filt_cnt_ff;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int_n_out <= 1'b1;
            int_n_oe <= 1'b0;
            int_pullup_en <= 1'b1;
            fmt_reset <= 1'b1;
            nrz_hiz <= 1'b1;
            mark_or_sector_pin_hiz <= 1'b1;
        end else begin
            int_n_out <= 1'b0;
            // pin only pulls low; the high level comes from the pull-up or the shared line
            int_n_oe <= mode_ff[`DEC_MODE_INT_EN] && int_request && !soft_rst;
            int_pullup_en <= !mode_ff[`DEC_MODE_PU_OFF];
            fmt_reset <= soft_rst;
            nrz_hiz <= soft_rst;
            mark_or_sector_pin_hiz <= soft_rst;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            branch_start <= 1'b0;
            invalid_nrz <= 1'b0;
            alt_branch_en <= 1'b0;
        end else begin
            branch_start <= !soft_rst && ((pin_ff.index_pin && !pin_prev_ff.index_pin)
                || (ctl_ff[`DEC_CTL_SECT_BR] && pin_ff.sector_pin && !pin_prev_ff.sector_pin));
            invalid_nrz <= !mode_ff[`DEC_MODE_ALT_BR] && cw_ctl_bit3 && !soft_rst;
            alt_branch_en <= mode_ff[`DEC_MODE_ALT_BR] && cw_ctl_bit3 && !soft_rst;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            filt_cnt_ff <= 2'd0;
            ref_clk_clean <= 1'b0;
        end else if (mode_ff[`DEC_MODE_FILT_OFF]) begin
            filt_cnt_ff <= 2'd0;
            ref_clk_clean <= pin_ff.ref_clk;
        end else if (pin_ff.ref_clk == ref_clk_clean) begin
            filt_cnt_ff <= 2'd0;
        end else if (filt_cnt_ff == `DEC_FILT_CYCLES) begin
            filt_cnt_ff <= 2'd0;
            ref_clk_clean <= pin_ff.ref_clk;
        end else if (pin_ff.ref_clk == pin_prev_ff.ref_clk) begin
            filt_cnt_ff <= 2'(filt_cnt_ff + 2'd1);
        end else begin
            filt_cnt_ff <= 2'd0;
        end
    end

    // ======================================================
    // checks
    a_soft_rst_hiz: assert property (@(posedge core_clk) disable iff (rst)
        soft_rst |=> nrz_hiz && mark_or_sector_pin_hiz && !ad_oe)
        else $error("software reset left a pin driven");
    a_rst_holds: assert property (@(posedge core_clk) disable iff (rst)
        soft_rst && !wr_ctl |=> soft_rst)
        else $error("formatter reset released without a write");
    a_status_set: assert property (@(posedge core_clk) disable iff (rst)
        soft_rst |=> syn_ff == '1)
        else $error("status not set during formatter reset");
    a_clear_defer: assert property (@(posedge core_clk) disable iff (rst)
        ctl_ff[`DEC_CTL_CLEAR] && disk_op_active && !wr_ctl |=> ctl_ff[`DEC_CTL_CLEAR])
        else $error("clear taken during disk operation");
    a_rev_len: assert property (@(posedge core_clk) disable iff (rst)
        eng_ff == dec_pkg::DEC_IDLE ##1 eng_ff == dec_pkg::DEC_REVERSE |-> ##7 eng_done)
        else $error("reversal did not take eight shifts");
    a_corr_limit: assert property (@(posedge core_clk) disable iff (rst)
        eng_ff == dec_pkg::DEC_CORRECT |-> bytes_ff < `DEC_CORR_MAX_BYTES)
        else $error("correction ran past 256 bytes");
    a_int_gate: assert property (@(posedge core_clk) disable iff (rst)
        !mode_ff[`DEC_MODE_INT_EN] |=> !int_n_oe)
        else $error("interrupt driven while disabled");
    a_no_decode: assert property (@(posedge core_clk) disable iff (rst)
        !$past(mode_ff[`DEC_MODE_INT_ACC]) |-> !int_reg_sel)
        else $error("interrupt range decoded while access off");
    a_sect_branch: assert property (@(posedge core_clk) disable iff (rst)
        branch_start && !$past(pin_ff.index_pin && !pin_prev_ff.index_pin)
        |-> $past(ctl_ff[`DEC_CTL_SECT_BR]))
        else $error("sector branch without enable");
    a_fire_preset: assert property (@(posedge core_clk) disable iff (rst)
        clr_now && fire |=> syn_ff == 56'h0)
        else $error("fire code preset not zero");

endmodule : dec_ctrl

`default_nettype wire

// ### tb/dec_mcu_model.sv
// microcontroller model on the muxed address/data bus
`timescale 1ns/1ps
`default_nettype none

module dec_mcu_model (
    input wire logic core_clk,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    input wire logic ecc_busy,
    output var logic ale,
    output var logic rd_n,
    output var logic wr_n,
    output logic [7:0] ad
);
    logic [7:0] drv_ff = 8'h00;
    logic drv_en_ff = 1'b0;

    initial begin
        ale = 1'b0;
        rd_n = 1'b1;
        wr_n = 1'b1;
    end

    // a released bus shows the inverse of the last value so stale data never reads back
    assign ad = ad_oe ? ad_out : (drv_en_ff ? drv_ff : ~drv_ff);

    // =====================================================
    // bus cycles
    task automatic addr_phase(input logic [7:0] a);
        @(posedge core_clk);
        ale <= 1'b1;
        drv_ff <= a;
        drv_en_ff <= 1'b1;
        repeat (6) @(posedge core_clk);
        ale <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : addr_phase

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_phase(a);
        drv_ff <= d;
        wr_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        wr_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        drv_en_ff <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic oe);
        while (ecc_busy !== 1'b0) @(posedge core_clk);
        addr_phase(a);
        drv_en_ff <= 1'b0;
        rd_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        d = ad;
        oe = ad_oe;
        rd_n <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask : rd
endmodule : dec_mcu_model
`default_nettype wire

// ### tb/testbench.sv
// self-checking testbench for the disk ecc control block
`timescale 1ns/1ps
`include "dec_regs.svh"
`default_nettype none

module testbench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic disk_op_active = 1'b0;
    logic data_bit = 1'b0;
    logic data_bit_valid = 1'b0;
    logic cw_ctl_bit3 = 1'b0;
    logic int_request = 1'b0;
    logic index_pin = 1'b0;
    logic sector_pin = 1'b0;
    logic ref_clk = 1'b0;
    logic ale, rd_n, wr_n, ad_oe, int_n_out, int_n_oe, int_pullup_en, int_reg_sel, fmt_reset;
    logic nrz_hiz, mark_or_sector_pin_hiz, branch_start, ref_clk_clean, invalid_nrz, alt_branch_en;
    logic correctable_found, ecc_busy;
    logic [7:0] ad, ad_out;
    dec_pkg::dec_pins_t pins;
    int fails = 0;
    int samples_checked = 0;
    int br_cnt = 0;
    int clean_cnt = 0;
    int busy_cnt = 0;

    assign pins = {ale, rd_n, wr_n, index_pin, sector_pin, ref_clk, ad};
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (branch_start === 1'b1) br_cnt++;
        if (ref_clk_clean === 1'b1) clean_cnt++;
        if (ecc_busy === 1'b1) busy_cnt++;
    end

    dec_ctrl u_dut (.core_clk, .rst, .pins, .disk_op_active, .data_bit, .data_bit_valid, .cw_ctl_bit3,
        .int_request, .ad_out, .ad_oe, .int_n_out, .int_n_oe, .int_pullup_en, .int_reg_sel, .fmt_reset,
        .nrz_hiz, .mark_or_sector_pin_hiz, .branch_start, .ref_clk_clean, .invalid_nrz, .alt_branch_en,
        .correctable_found, .ecc_busy);
    dec_mcu_model u_mcu (.core_clk, .ad_out, .ad_oe, .ecc_busy, .ale, .rd_n, .wr_n, .ad);

    // =====================================================
    // helpers
    task automatic conclude;
        if (fails == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic flag(input logic got, input logic exp, input string what);
        chk({7'h00, got}, {7'h00, exp}, what);
    endtask : flag

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        u_mcu.wr(a, d);
    endtask : wreg

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic oe;
        u_mcu.rd(a, d, oe);
        flag(oe, 1'b1, $sformatf("drive %h", a));
        chk(d, exp, $sformatf("reg %h", a));
    endtask : rchk

    task automatic status(input logic [7:0] exp);
        for (int i = 0; i < 4; i++) rchk(`DEC_OFS_ECC_STATUS0 + 8'(i), exp);
    endtask : status

    // kind 0 index, 1 sector, else reference clock
    task automatic pulse(input int kind, input int len);
        @(posedge core_clk);
        case (kind)
            0: index_pin <= 1'b1;
            1: sector_pin <= 1'b1;
            default: ref_clk <= 1'b1;
        endcase
        repeat (len) @(posedge core_clk);
        index_pin <= 1'b0;
        sector_pin <= 1'b0;
        ref_clk <= 1'b0;
        repeat (10) @(posedge core_clk);
    endtask : pulse

    // =====================================================
    // scenarios
    task automatic t_reset;
        @(negedge core_clk);
        flag(fmt_reset, 1'b1, "hard reset");
        flag(nrz_hiz, 1'b1, "nrz hiz");
        flag(mark_or_sector_pin_hiz, 1'b1, "mark hiz");
        wreg(`DEC_OFS_ECC_CONTROL, 8'h00);
        @(negedge core_clk);
        flag(fmt_reset, 1'b0, "release");
        flag(nrz_hiz, 1'b0, "nrz driven");
        rchk(`DEC_OFS_ECC_CONTROL, 8'h00);
        rchk(`DEC_OFS_ECC_SHIFT_COUNTER, 8'h00);
        status(8'hFF);
        rchk(`DEC_OFS_FMT_MODE, 8'h00);
    endtask : t_reset

    task automatic t_mode;
        @(posedge core_clk);
        int_request <= 1'b1;
        cw_ctl_bit3 <= 1'b1;
        wreg(`DEC_OFS_FMT_MODE, 8'h18);
        @(negedge core_clk);
        flag(int_n_oe, 1'b1, "int pulled");
        flag(int_pullup_en, 1'b0, "pullup off");
        flag(int_n_out, 1'b0, "int level low");
        flag(invalid_nrz, 1'b1, "invalid nrz");
        flag(alt_branch_en, 1'b0, "alt off");
        rchk(`DEC_OFS_FMT_MODE, 8'h18);
        wreg(`DEC_OFS_FMT_MODE, 8'h40);
        @(negedge core_clk);
        flag(int_n_oe, 1'b0, "int gated");
        flag(int_pullup_en, 1'b1, "pullup on");
        flag(alt_branch_en, 1'b1, "alt on");
        flag(invalid_nrz, 1'b0, "invalid off");
    endtask : t_mode

    task automatic t_decode;
        logic [7:0] modes [3] = '{8'h00, 8'h02, 8'h06};
        logic [7:0] addrs [4] = '{8'h47, 8'h48, 8'h60, 8'h6F};
        logic [7:0] d;
        logic oe, exp;
        foreach (modes[m]) begin
            wreg(`DEC_OFS_FMT_MODE, modes[m]);
            foreach (addrs[k]) begin
                exp = modes[m][2] ? (addrs[k] inside {[8'h40:8'h47]}) : (addrs[k] inside {[8'h60:8'h6F]});
                u_mcu.rd(addrs[k], d, oe);
                @(negedge core_clk);
                flag(int_reg_sel, exp & modes[m][1], "int decode");
                flag(oe, 1'b0, "outside map");
            end
        end
    endtask : t_decode

    task automatic t_branch_filter;
        int base;
        base = br_cnt;
        pulse(1, 6);
        chk(8'(br_cnt - base), 8'h00, "sector masked");
        wreg(`DEC_OFS_ECC_CONTROL, 8'h10);
        pulse(1, 6);
        pulse(0, 6);
        chk(8'(br_cnt - base), 8'h02, "sector and index");
        wreg(`DEC_OFS_FMT_MODE, 8'h00);
        base = clean_cnt;
        pulse(2, 2);
        chk(8'(clean_cnt - base), 8'h00, "glitch filtered");
        wreg(`DEC_OFS_FMT_MODE, 8'h01);
        base = clean_cnt;
        pulse(2, 2);
        flag(clean_cnt != base, 1'b1, "glitch passed");
    endtask : t_branch_filter

    task automatic t_clear_shift;
        int base;
        wreg(`DEC_OFS_FMT_MODE, 8'h20);
        wreg(`DEC_OFS_ECC_CONTROL, 8'h08);
        status(8'h00);
        @(posedge core_clk);
        disk_op_active <= 1'b1;
        wreg(`DEC_OFS_FMT_MODE, 8'h00);
        wreg(`DEC_OFS_ECC_CONTROL, 8'h08);
        rchk(`DEC_OFS_ECC_STATUS3, 8'h00);
        @(posedge core_clk);
        disk_op_active <= 1'b0;
        repeat (4) @(posedge core_clk);
        status(8'hFF);
        rchk(`DEC_OFS_ECC_CONTROL, 8'h00);
        base = busy_cnt;
        wreg(`DEC_OFS_ECC_SHIFT_COUNTER, 8'hA5);
        wreg(`DEC_OFS_ECC_CONTROL, 8'h02);
        rchk(`DEC_OFS_ECC_CONTROL, 8'h00);
        chk(8'(busy_cnt - base), 8'h08, "reverse shifts");
        rchk(`DEC_OFS_ECC_SHIFT_COUNTER, 8'h00);
        flag(correctable_found, 1'b0, "no find in reversal");
        base = busy_cnt;
        wreg(`DEC_OFS_ECC_CONTROL, 8'h03);
        repeat (2100) @(posedge core_clk);
        flag((busy_cnt - base) inside {[1:2050]}, 1'b1, "correct bound");
        rchk(`DEC_OFS_ECC_CONTROL, 8'h01);
    endtask : t_clear_shift

    task automatic t_resets;
        wreg(`DEC_OFS_FMT_MODE, 8'h04);
        wreg(`DEC_OFS_ECC_SHIFT_COUNTER, 8'h33);
        wreg(`DEC_OFS_ECC_CONTROL, 8'h20);
        @(negedge core_clk);
        flag(fmt_reset, 1'b1, "soft reset");
        flag(mark_or_sector_pin_hiz, 1'b1, "mark hiz");
        wreg(`DEC_OFS_FMT_MODE, 8'h08);
        wreg(`DEC_OFS_ECC_CONTROL, 8'h00);
        rchk(`DEC_OFS_FMT_MODE, 8'h00);
        rchk(`DEC_OFS_ECC_SHIFT_COUNTER, 8'h00);
        status(8'hFF);
        wreg(`DEC_OFS_FMT_MODE, 8'h40);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (8) @(negedge core_clk);
        flag(alt_branch_en, 1'b0, "alt cleared");
        flag(invalid_nrz, 1'b0, "invalid held in reset");
        flag(fmt_reset, 1'b1, "hard reset again");
        wreg(`DEC_OFS_ECC_CONTROL, 8'h00);
        @(negedge core_clk);
        flag(invalid_nrz, 1'b1, "invalid back");
        rchk(`DEC_OFS_FMT_MODE, 8'h00);
    endtask : t_resets

    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        repeat (8) @(posedge core_clk);
        t_reset;
        t_mode;
        t_decode;
        t_branch_filter;
        t_clear_shift;
        t_resets;
        conclude;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        conclude;
    end
endmodule : testbench
`default_nettype wire
